// *** logic/gtm_pkg.sv ***
package gtm_pkg;

    // register offsets
    localparam logic [7:0] OFS_TIMER_CONTROL      = 8'h11;
    localparam logic [7:0] OFS_GP_TIMEOUT_HIGH    = 8'h12;
    localparam logic [7:0] OFS_GP_TIMEOUT_LOW     = 8'h13;
    localparam logic [7:0] OFS_MAIN_IRQ_MASK      = 8'h14;
    localparam logic [7:0] OFS_TIMER_NFC_IRQ_MASK = 8'h15;
    localparam logic [7:0] OFS_MAIN_IRQ_STATUS    = 8'h17;
    localparam logic [7:0] OFS_TIMER_NFC_STATUS   = 8'h18;

    // reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_MASK          = 8'h00;
    localparam logic [7:0] RST_GP_TIMEOUT    = 8'h00;

    // timer control fields
    localparam int TRIG_MSB     = 7;
    localparam int TRIG_LSB     = 5;
    localparam int NRT_EMV_BIT  = 1;
    localparam int NRT_STEP_BIT = 0;
    localparam logic [7:0] TIMER_CONTROL_WMASK = 8'he3;
    localparam logic [7:0] MAIN_MASK_WMASK     = 8'hfc;

    // timer/nfc status and mask bit positions
    localparam int TN_DCT  = 7;
    localparam int TN_NRE  = 6;
    localparam int TN_GPE  = 5;

    // carrier periods per timer step
    localparam int GP_STEP_FC       = 8;
    localparam int NRT_STEP_FC_FINE = 64;
    localparam int NRT_STEP_FC_COARSE = 4096;
    localparam logic [12:0] NRT_DIV_FINE   = 13'(NRT_STEP_FC_FINE);
    localparam logic [12:0] NRT_DIV_COARSE = 13'(NRT_STEP_FC_COARSE);
    localparam logic [3:0]  GP_DIV         = 4'(GP_STEP_FC);

    // trigger source encodings
    typedef enum logic [2:0] {
        TRIG_NONE     = 3'h0,
        TRIG_RX_END   = 3'h1,
        TRIG_RX_START = 3'h2,
        TRIG_NFC_TX   = 3'h3
    } gtm_trig_t;

    // register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gtm_bus_t;

    // hardware events from the front end, one-cycle pulses on i_mclk
    typedef struct packed {
        logic osc_stable;
        logic fifo_level;
        logic rx_start;
        logic rx_end;
        logic tx_end;
        logic bit_collision;
        logic cmd_done;
        logic field_on;
        logic field_off;
        logic ca_collision;
        logic guard_expired;
        logic nfc_rate_found;
    } gtm_evt_t;

    // carrier-clock step divider terminal test
    function automatic logic div_done(input logic [12:0] cnt, input logic [12:0] div);
        div_done = (cnt == 13'(div - 13'h1));
    endfunction

endpackage

// *** logic/gtm_step_div.sv ***
`timescale 1ns/100ps
// counts carrier ticks and emits one pulse per step
module gtm_step_div (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // control
    input  wire logic        i_run,
    input  wire logic        i_fc_tick,
    input  wire logic [12:0] i_div,
    // step pulse
    output logic             o_step
);
    import gtm_pkg::*;

    logic [12:0] cnt_r;

    // restart on every stop so that the first step is always a full one
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= 13'h0;
        end else if (!i_run) begin
            cnt_r <= 13'h0;
        end else if (i_fc_tick) begin
            cnt_r <= div_done(cnt_r, i_div) ? 13'h0 : 13'(cnt_r + 13'h1);
        end
    end

    assign o_step = i_run && i_fc_tick && div_done(cnt_r, i_div);

endmodule // gtm_step_div

// *** logic/gtm_timer_core.sv ***
`timescale 1ns/100ps
module gtm_timer_core (
    // clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_sys_rst,
    // register port
    input  wire gtm_pkg::gtm_bus_t i_bus,
    output logic [7:0]           o_rdata,
    // commands and carrier
    input  wire logic            i_set_default,
    input  wire logic            i_gp_start_cmd,
    input  wire logic            i_nrt_start_cmd,
    input  wire logic            i_fc_tick,
    input  wire logic [15:0]     i_nrt_count,
    input  wire gtm_pkg::gtm_evt_t i_evt,
    // status outputs
    output logic                 o_gp_running,
    output logic                 o_nrt_running,
    output logic                 o_nrt_emv,
    output logic                 o_field_off_req,
    output logic                 o_irq
);
    import gtm_pkg::*;

    logic [7:0]  timer_control_r;
    logic [7:0]  gp_high_r;
    logic [7:0]  gp_low_r;
    logic [7:0]  main_mask_r;
    logic [7:0]  tn_mask_r;
    logic [7:0]  main_stat_r;
    logic [7:0]  tn_stat_r;
    logic [7:0]  main_stat_nxt;
    logic [7:0]  tn_stat_nxt;
    logic [15:0] gp_cnt_r;
    logic [15:0] nrt_cnt_r;
    logic        gp_run_r;
    logic        nrt_run_r;
    logic        nfc_trig_r;
    logic        gp_trig;
    logic        gp_step;
    logic        nrt_step;
    logic        gp_expire;
    logic        nrt_expire;
    logic        nrt_start;
    logic        main_rd;
    logic [7:0]  main_evt;
    logic [7:0]  tn_evt;
    gtm_trig_t   trig;

    function automatic logic wr_hit(input gtm_bus_t b, input logic [7:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    assign trig = gtm_trig_t'(timer_control_r[TRIG_MSB:TRIG_LSB]);
    // only the main status read clears flags; a timer/nfc status read leaves them
    assign main_rd = i_bus.rd && (i_bus.addr == OFS_MAIN_IRQ_STATUS);

    // hardware trigger; 1xx codes fall to no trigger by the default arm
    always_comb begin
        unique case (trig)
            TRIG_RX_END:   gp_trig = i_evt.rx_end;
            TRIG_RX_START: gp_trig = i_evt.rx_start;
            TRIG_NFC_TX:   gp_trig = i_evt.tx_end;
            default:       gp_trig = 1'b0;
        endcase
    end

    // control register; reserved bits never store
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            timer_control_r <= RST_TIMER_CONTROL;
        end else if (i_set_default) begin
            timer_control_r <= RST_TIMER_CONTROL;
        end else if (wr_hit(i_bus, OFS_TIMER_CONTROL)) begin
            timer_control_r <= i_bus.wdata & TIMER_CONTROL_WMASK;
        end
    end

    // timeout bytes; no documented default, cleared for determinism
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gp_high_r <= RST_GP_TIMEOUT;
            gp_low_r  <= RST_GP_TIMEOUT;
        end else begin
            if (wr_hit(i_bus, OFS_GP_TIMEOUT_HIGH)) begin
                gp_high_r <= i_bus.wdata;
            end
            if (wr_hit(i_bus, OFS_GP_TIMEOUT_LOW)) begin
                gp_low_r <= i_bus.wdata;
            end
        end
    end

    // mask registers
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            main_mask_r <= RST_MASK;
            tn_mask_r   <= RST_MASK;
        end else if (i_set_default) begin
            main_mask_r <= RST_MASK;
            tn_mask_r   <= RST_MASK;
        end else begin
            if (wr_hit(i_bus, OFS_MAIN_IRQ_MASK)) begin
                main_mask_r <= i_bus.wdata & MAIN_MASK_WMASK;
            end
            if (wr_hit(i_bus, OFS_TIMER_NFC_IRQ_MASK)) begin
                tn_mask_r <= i_bus.wdata;
            end
        end
    end

    // step dividers from the carrier tick
    gtm_step_div u_gp_div (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_run     (gp_run_r),
        .i_fc_tick (i_fc_tick),
        .i_div     (13'(GP_DIV)),
        .o_step    (gp_step)
    );

    gtm_step_div u_nrt_div (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_run     (nrt_run_r),
        .i_fc_tick (i_fc_tick),
        .i_div     (timer_control_r[NRT_STEP_BIT] ? NRT_DIV_COARSE
                                                  : NRT_DIV_FINE),
        .o_step    (nrt_step)
    );

    assign gp_expire  = gp_run_r && gp_step && (gp_cnt_r == 16'h1);
    assign nrt_expire = nrt_run_r && nrt_step && (nrt_cnt_r == 16'h1);
    assign nrt_start  = i_nrt_start_cmd && (i_nrt_count != 16'h0);

    // general purpose timer; a zero timeout never runs
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gp_run_r   <= 1'b0;
            gp_cnt_r   <= 16'h0;
            nfc_trig_r <= 1'b0;
        end else if (i_gp_start_cmd || gp_trig) begin
            gp_cnt_r   <= {gp_high_r, gp_low_r};
            gp_run_r   <= ({gp_high_r, gp_low_r} != 16'h0);
            nfc_trig_r <= !i_gp_start_cmd && (trig == TRIG_NFC_TX);
        end else if (gp_expire) begin
            gp_run_r <= 1'b0;
            gp_cnt_r <= 16'h0;
        end else if (gp_run_r && gp_step) begin
            gp_cnt_r <= 16'(gp_cnt_r - 16'h1);
        end
    end

    // field-off request held until the next start, by software command or hardware trigger
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_field_off_req <= 1'b0;
        end else if (gp_expire && nfc_trig_r) begin
            o_field_off_req <= 1'b1;
        end else if (i_gp_start_cmd || gp_trig) begin
            o_field_off_req <= 1'b0;
        end
    end

    // no-response timer
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nrt_run_r <= 1'b0;
            nrt_cnt_r <= 16'h0;
        end else if (nrt_start) begin
            nrt_run_r <= 1'b1;
            nrt_cnt_r <= i_nrt_count;
        end else if (nrt_expire) begin
            nrt_run_r <= 1'b0;
            nrt_cnt_r <= 16'h0;
        end else if (nrt_run_r && nrt_step) begin
            nrt_cnt_r <= 16'(nrt_cnt_r - 16'h1);
        end
    end

    // event vectors in status bit order
    assign main_evt = {i_evt.osc_stable, i_evt.fifo_level, i_evt.rx_start, i_evt.rx_end,
                       i_evt.tx_end, i_evt.bit_collision, 2'b00};
    assign tn_evt   = {i_evt.cmd_done, nrt_expire, gp_expire, i_evt.field_on,
                       i_evt.field_off, i_evt.ca_collision, i_evt.guard_expired,
                       i_evt.nfc_rate_found};

    // status flags set regardless of mask; set beats read-clear
    // timer/nfc byte first, so the summary bit sees this cycle's value
    always_comb begin
        tn_stat_nxt   = (main_rd ? 8'h00 : tn_stat_r) | tn_evt;
        main_stat_nxt = (main_rd ? 8'h00 : main_stat_r) | main_evt;
        main_stat_nxt[1] = |tn_stat_nxt;
        main_stat_nxt[0] = 1'b0;
        if (i_set_default) begin
            main_stat_nxt = 8'h00;
            tn_stat_nxt   = 8'h00;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            main_stat_r <= 8'h00;
            tn_stat_r   <= 8'h00;
        end else begin
            main_stat_r <= main_stat_nxt;
            tn_stat_r   <= tn_stat_nxt;
        end
    end

    // request only from unmasked flags
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(main_stat_nxt[7:2] & ~main_mask_r[7:2])
                   | |(tn_stat_nxt & ~tn_mask_r);
        end
    end

    // read data one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                OFS_TIMER_CONTROL:      o_rdata <= timer_control_r;
                OFS_GP_TIMEOUT_HIGH:    o_rdata <= gp_high_r;
                OFS_GP_TIMEOUT_LOW:     o_rdata <= gp_low_r;
                OFS_MAIN_IRQ_MASK:      o_rdata <= main_mask_r;
                OFS_TIMER_NFC_IRQ_MASK: o_rdata <= tn_mask_r;
                OFS_MAIN_IRQ_STATUS:    o_rdata <= main_stat_r;
                OFS_TIMER_NFC_STATUS:   o_rdata <= tn_stat_r;
                default:                o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    assign o_gp_running  = gp_run_r;
    assign o_nrt_running = nrt_run_r;
    assign o_nrt_emv     = timer_control_r[NRT_EMV_BIT];

    // checks
    property p_rsvd_zero;
        @(posedge i_mclk) disable iff (i_sys_rst)
        timer_control_r[4:2] == 3'b000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits stored");

    property p_default;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_set_default |=> (timer_control_r == 8'h00 && main_mask_r == 8'h00 && tn_mask_r == 8'h00);
    endproperty
    a_default: assert property (p_default) else $error("set default missed");

    property p_none_trig;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (trig[2] || trig == TRIG_NONE) && !gp_run_r && !i_gp_start_cmd |=> !gp_run_r;
    endproperty
    a_none_trig: assert property (p_none_trig) else $error("gp started without cause");

    property p_rx_end;
        @(posedge i_mclk) disable iff (i_sys_rst)
        trig == TRIG_RX_END && i_evt.rx_end && {gp_high_r, gp_low_r} != 16'h0 |=> gp_run_r;
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("rx end trigger lost");

    property p_field_off;
        @(posedge i_mclk) disable iff (i_sys_rst)
        gp_expire && nfc_trig_r |=> o_field_off_req;
    endproperty
    a_field_off: assert property (p_field_off) else $error("field not dropped");

    property p_nrt_zero;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_nrt_start_cmd && i_nrt_count == 16'h0 && !nrt_run_r |=> !nrt_run_r;
    endproperty
    a_nrt_zero: assert property (p_nrt_zero) else $error("zero nrt started");

    property p_gpe_flag;
        @(posedge i_mclk) disable iff (i_sys_rst)
        gp_expire && !i_set_default |=> tn_stat_r[TN_GPE];
    endproperty
    a_gpe_flag: assert property (p_gpe_flag) else $error("gp expiry flag lost");

    property p_masked;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (main_mask_r == 8'hfc && tn_mask_r == 8'hff) |=> !o_irq;
    endproperty
    a_masked: assert property (p_masked) else $error("masked source raised irq");

    // a start with a nonzero timeout loads the full count and runs
    sequence s_gp_start;
        (i_gp_start_cmd || gp_trig) && ({gp_high_r, gp_low_r} != 16'h0);
    endsequence

    property p_gp_load;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_gp_start |=> gp_run_r && (gp_cnt_r == {$past(gp_high_r), $past(gp_low_r)});
    endproperty
    a_gp_load: assert property (p_gp_load) else $error("gp timeout not loaded");

    // a nonzero no-response count starts the timer with that count
    sequence s_nrt_load;
        i_nrt_start_cmd && (i_nrt_count != 16'h0);
    endsequence

    property p_nrt_load;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_nrt_load |=> nrt_run_r && (nrt_cnt_r == $past(i_nrt_count));
    endproperty
    a_nrt_load: assert property (p_nrt_load) else $error("nrt count not loaded");

    // an unmasked expiry reaches the request in the cycle its flag appears
    sequence s_gpe_open;
        gp_expire && !tn_mask_r[TN_GPE] && !i_set_default;
    endsequence

    property p_gpe_irq;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_gpe_open |=> o_irq && tn_stat_r[TN_GPE];
    endproperty
    a_gpe_irq: assert property (p_gpe_irq) else $error("unmasked gp expiry gave no irq");

    // a status read with no event pending leaves both status bytes clear
    sequence s_stat_read;
        main_rd && (main_evt == 8'h00) && (tn_evt == 8'h00) && !i_set_default;
    endsequence

    property p_read_clear;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_stat_read |=> (main_stat_r == 8'h00) && (tn_stat_r == 8'h00);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

endmodule // gtm_timer_core

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import gtm_pkg::*;
    logic        i_mclk    = 1'b0;
    logic        i_sys_rst = 1'b1;
    gtm_bus_t    bus       = '0;
    gtm_evt_t    evt       = '0;
    logic        set_dflt  = 1'b0;
    logic        gp_cmd    = 1'b0;
    logic        nrt_cmd   = 1'b0;
    logic        fc        = 1'b0;
    logic [15:0] nrt_cnt   = 16'h0000;
    logic [7:0]  rdata;
    logic        gp_run, nrt_run, nrt_emv, fld_off, irq;
    int          fail_count = 0;
    int          n_compared = 0;

    gtm_timer_core uut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
        .i_set_default(set_dflt), .i_gp_start_cmd(gp_cmd), .i_nrt_start_cmd(nrt_cmd),
        .i_fc_tick(fc), .i_nrt_count(nrt_cnt), .i_evt(evt), .o_gp_running(gp_run),
        .o_nrt_running(nrt_run), .o_nrt_emv(nrt_emv), .o_field_off_req(fld_off), .o_irq(irq)
    );

    // free-running system clock
    always #10 i_mclk = ~i_mclk;

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // one-cycle command pulse: 0 set default, 1 gp start, 2 nrt start
    task automatic cmd(input int which);
        @(posedge i_mclk);
        set_dflt <= (which == 0);
        gp_cmd   <= (which == 1);
        nrt_cmd  <= (which == 2);
        @(posedge i_mclk);
        set_dflt <= 1'b0;
        gp_cmd   <= 1'b0;
        nrt_cmd  <= 1'b0;
    endtask

    // bus cycles: one strobe cycle, then an idle cycle before the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge i_mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_mclk);
        bus <= '0;
        #1 chk(what, exp, rdata);
    endtask

    task automatic pulse_evt(input int k);
        @(posedge i_mclk);
        evt <= gtm_evt_t'(12'h001 << k);
        @(posedge i_mclk);
        evt <= '0;
    endtask

    // carrier ticks every other cycle, as a slow carrier would arrive
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            fc <= 1'b1;
            @(posedge i_mclk);
            fc <= 1'b0;
        end
    endtask

    // still running one tick short of the count, stopped shortly after the last tick
    task automatic expire(input bit nrt, input int n, input string what);
        int k;
        ticks(n - 1);
        cyc(2);
        #1 chk(what, 8'h01, nrt ? nrt_run : gp_run);
        ticks(1);
        k = 0;
        while ((nrt ? nrt_run : gp_run) !== 1'b0 && k < 8) begin
            @(posedge i_mclk);
            #1 k++;
        end
        if (k == 8) begin
            fail_count++;
            $display("CHECK FAILED %s expected stop seen running", what);
            finish_test();
        end
    endtask

    task automatic t_dflt(input string what);
        rd(OFS_TIMER_CONTROL, RST_TIMER_CONTROL, what);
        rd(OFS_MAIN_IRQ_MASK, RST_MASK, what);
        rd(OFS_TIMER_NFC_IRQ_MASK, RST_MASK, what);
        rd(8'h20, 8'h00, "unmapped");
        $display("test defaults %s done", what);
    endtask

    task automatic t_regs();
        wr(OFS_TIMER_CONTROL, 8'hff);
        rd(OFS_TIMER_CONTROL, 8'he3, "ctrl_rsvd");
        cyc(1);
        #1 chk("rdata_idle", 8'h00, rdata);
        chk("nrt_emv", 8'h01, nrt_emv);
        wr(OFS_MAIN_IRQ_MASK, 8'hff);
        rd(OFS_MAIN_IRQ_MASK, 8'hfc, "main_mask");
        wr(OFS_TIMER_NFC_IRQ_MASK, 8'hff);
        rd(OFS_TIMER_NFC_IRQ_MASK, 8'hff, "tn_mask");
        cmd(0);
        t_dflt("set_default");
        chk("nrt_emv_dflt", 8'h00, nrt_emv);
        $display("test registers done");
    endtask

    // each of the twelve event inputs: masked sets its flag quietly, unmasked raises the request
    task automatic t_mask();
        int k;
        logic [7:0] a, b, m;
        for (k = 0; k < 12; k++) begin
            a = (k > 5) ? OFS_MAIN_IRQ_MASK : OFS_TIMER_NFC_IRQ_MASK;
            b = (k > 5) ? 8'h01 << (k - 4) : (k == 5 ? 8'h80 : 8'h01 << k);
            m = (k > 5) ? b : 8'h02;
            wr(a, b);
            pulse_evt(k);
            cyc(2);
            #1 chk("irq_masked", 8'h00, irq);
            if (k < 6) rd(OFS_TIMER_NFC_STATUS, b, "tn_flag");
            rd(OFS_MAIN_IRQ_STATUS, m, "main_flag");
            wr(a, 8'h00);
            pulse_evt(k);
            cyc(2);
            #1 chk("irq_open", 8'h01, irq);
            rd(OFS_MAIN_IRQ_STATUS, m, "main_flag2");
            cyc(1);
            #1 chk("irq_cleared", 8'h00, irq);
        end
        $display("test masks done");
    endtask

    task automatic t_gp();
        wr(OFS_TIMER_NFC_IRQ_MASK, 8'h20);
        wr(OFS_GP_TIMEOUT_HIGH, 8'h00);
        wr(OFS_GP_TIMEOUT_LOW, 8'h01);
        cmd(1);
        expire(1'b0, 8, "gp_one_unit");
        cyc(2);
        #1 chk("irq_gpe_masked", 8'h00, irq);
        rd(OFS_TIMER_NFC_STATUS, 8'h20, "gpe_flag");
        rd(OFS_MAIN_IRQ_STATUS, 8'h02, "gpe_sum");
        wr(OFS_TIMER_NFC_IRQ_MASK, 8'h00);
        wr(OFS_GP_TIMEOUT_HIGH, 8'h01);
        rd(OFS_GP_TIMEOUT_HIGH, 8'h01, "gp_high");
        wr(OFS_GP_TIMEOUT_LOW, 8'h02);
        rd(OFS_GP_TIMEOUT_LOW, 8'h02, "gp_low");
        cmd(1);
        expire(1'b0, 258 * 8, "gp_16bit");
        cyc(2);
        #1 chk("irq_gpe", 8'h01, irq);
        rd(OFS_TIMER_NFC_STATUS, 8'h20, "gpe_flag2");
        rd(OFS_MAIN_IRQ_STATUS, 8'h02, "gpe_sum2");
        $display("test gp timer done");
    endtask

    task automatic t_trig();
        int c, e;
        wr(OFS_GP_TIMEOUT_HIGH, 8'h00);
        wr(OFS_GP_TIMEOUT_LOW, 8'h01);
        for (c = 0; c < 8; c++) begin
            wr(OFS_TIMER_CONTROL, {c[2:0], 5'h1f});
            rd(OFS_TIMER_CONTROL, {c[2:0], 5'h03}, "ctrl_trig");
            for (e = 1; e < 4; e++) begin
                pulse_evt(e == 1 ? 8 : (e == 2 ? 9 : 7));
                cyc(1);
                #1 chk("gp_trig", 8'(c == e), gp_run);
                if (c == e) begin
                    expire(1'b0, 8, "gp_trig_run");
                    cyc(1);
                    #1 chk("field_off", 8'(c == 3), fld_off);
                end
            end
        end
        wr(OFS_TIMER_CONTROL, 8'h00);
        cmd(1);
        cyc(1);
        #1 chk("field_off_restart", 8'h00, fld_off);
        expire(1'b0, 8, "gp_after_trig");
        rd(OFS_MAIN_IRQ_STATUS, 8'h3a, "trig_flags");
        $display("test triggers done");
    endtask

    task automatic t_nrt();
        cmd(2);
        cyc(2);
        #1 chk("nrt_zero", 8'h00, nrt_run);
        @(posedge i_mclk);
        nrt_cnt <= 16'h0001;
        cmd(2);
        cyc(1);
        expire(1'b1, 64, "nrt_fine_step");
        rd(OFS_TIMER_NFC_STATUS, 8'h40, "nre_flag");
        rd(OFS_MAIN_IRQ_STATUS, 8'h02, "nre_sum");
        wr(OFS_TIMER_CONTROL, 8'h01);
        cmd(2);
        cyc(1);
        expire(1'b1, 4096, "nrt_coarse_step");
        rd(OFS_TIMER_NFC_STATUS, 8'h40, "nre_flag2");
        $display("test no-response timer done");
    endtask

    // a reset in mid-run drops a running timer and restores power-up values
    task automatic t_reset();
        wr(OFS_TIMER_CONTROL, 8'h22);
        wr(OFS_TIMER_NFC_IRQ_MASK, 8'h5a);
        cmd(2);
        cyc(1);
        #1 chk("nrt_before_rst", 8'h01, nrt_run);
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        cyc(2);
        i_sys_rst <= 1'b0;
        #1 chk("nrt_after_rst", 8'h00, nrt_run);
        chk("emv_after_rst", 8'h00, nrt_emv);
        t_dflt("mid_reset");
        $display("test mid-run reset done");
    endtask

    initial begin
        cyc(20);
        i_sys_rst <= 1'b0;
        t_dflt("reset");
        t_regs();
        t_mask();
        t_gp();
        t_trig();
        t_nrt();
        t_reset();
        finish_test();
    end
endmodule // testbench
